// ===== aacs_clk_src.sv
// Behavioural clock and fault source facing the register bank.
// Assumes the bench requests settings; lines change off the clock edge.
`timescale 1ns/1ns
`default_nettype none
module aacs_clk_src (
  // Requests
  input  wire [2:0] fs_i,
  input  wire [2:0] mr_i,
  input  wire [1:0] br_i,
  input  wire [5:0] fault_i,
  // Detector and fault lines
  output reg  [2:0] det_fs_o,
  output reg  [2:0] det_mratio_o,
  output reg  [1:0] det_bratio_o,
  output reg  [5:0] ev_o
);
  // Illegal pairings are never presented; the last legal setting stays
  wire legal = !(mr_i < 3'h2 && fs_i != 3'h3)
    && !(mr_i == 3'h2 && fs_i != 3'h0 && fs_i != 3'h3)
    && !(mr_i == 3'h3 && fs_i == 3'h6);
  initial {det_fs_o, det_mratio_o, det_bratio_o, ev_o} = {8'h6c, 6'h00};
  always @(fs_i, mr_i, br_i) #3 if (legal) {det_fs_o, det_mratio_o, det_bratio_o} = {fs_i, mr_i, br_i};
  always @(fault_i) ev_o <= #3 fault_i;
endmodule
`default_nettype wire

// ===== aacs_ctrl_regs.v
// Control and status register bank of a stereo digital audio amplifier.
// Assumes clock-detector and fault event inputs arrive from other domains.
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
`include "aacs_regs.vh"

// What this block does
// RULE1: Clock status bits 7:5 report detected sample rate code.
// RULE2: Clock status bits 4:2 report detected master-clock ratio code.
// RULE3: Bit clock 64/32 Fs always accepted; 48 Fs only at 192/384 ratios.
// RULE4: Source uses ratios 64 and 128 only at 44.1/48 kHz.
// RULE5: Source uses ratio 192 only at 32, 44.1 or 48 kHz.
// RULE6: Source never uses ratio 256 at 8 kHz.
// RULE7: Identification register returns fixed code in bits 6:0, bit 7 zero.
// RULE8: Error flags are sticky; only a host write of zeros clears them.
// RULE9: Host clears error register then reads it to test persistence.
// RULE10: Error bits: 7 mclk, 6 pll, 5 sclk, 4 lrclk, 3 slip, 1 overcurrent.
// RULE11: Master-clock count per frame change raises master-clock error.
// RULE12: Bit-clock count per frame change raises bit-clock error.
// RULE13: Frame-clock rate change raises frame error; phase drift raises slip.
// RULE14: System control 1 bit 7 enables dc-blocking filter, default on.
// RULE15: System control 1 bit 5 picks hard or ramped unmute after clock error.
// RULE16: System control 1 bits 1:0 select de-emphasis, 01 reserved.
// RULE17: Format codes 0-5 select right-justified and I2S, 16/20/24 bit.
// RULE18: Codes 6-8 left-justified; 9-15 reserved; default 24-bit I2S.
// RULE19: System control 2 bit 6 forces all-channel shutdown, default set.
// RULE20: Soft mute bit 0 channel 1, bit 1 channel 2; 1 gives 50% duty.
// RULE21: Host avoids reserved registers and encodings.
// RULE22: Volume ramp step count 512, 1024, 2048 or 256 from config field.
// RULE23: Ramp step period 125, 90.7 or 83.3 us by sample-rate family.
// RULE24: Writes to clock status and identification registers are ignored.
module aacs_ctrl_regs #(
  parameter [6:0] REV_ID = 7'h2a  // Arbitrary neutral identification value
) (
  // Clock and reset
  input  wire       clock_i,
  input  wire       srst_i,
  // Register port
  input  wire [7:0] addr_i,
  input  wire [7:0] wdata_i,
  input  wire       wr_i,
  input  wire       rd_i,
  output reg  [7:0] rdata_o,
  // Clock detector results (asynchronous)
  input  wire [2:0] det_fs_i,
  input  wire [2:0] det_mratio_i,
  input  wire [1:0] det_bratio_i,
  // Fault events (asynchronous levels, pulse-stretched at source)
  input  wire       ev_mclk_i,
  input  wire       ev_pll_i,
  input  wire       ev_sclk_i,
  input  wire       ev_lrclk_i,
  input  wire       ev_slip_i,
  input  wire       ev_ocur_i,
  // Controls to the datapath
  output reg        dc_block_en_o,
  output reg        hard_unmute_o,
  output reg  [1:0] deemph_o,
  output reg  [3:0] ser_fmt_o,
  output reg        shutdown_o,
  output reg  [1:0] soft_mute_o,
  output reg        sclk_ok_o,
  output reg        ramp_tick_o,
  output reg  [11:0] ramp_steps_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  localparam SW = 14;
  wire [SW-1:0] async_w = {det_fs_i, det_mratio_i, det_bratio_i, ev_mclk_i,
                           ev_pll_i, ev_sclk_i, ev_lrclk_i, ev_slip_i, ev_ocur_i};
  reg  [SW-1:0] sync1_q;
  reg  [SW-1:0] sync2_q;
  always @(posedge clock_i) begin
    if (srst_i) begin
      sync1_q <= {SW{1'b0}};
      sync2_q <= {SW{1'b0}};
    end else begin
      sync1_q <= async_w;
      sync2_q <= sync1_q;
    end
  end
  wire [2:0] fs_w     = sync2_q[13:11];
  wire [2:0] mratio_w = sync2_q[10:8];
  wire [1:0] bratio_w = sync2_q[7:6];
  wire [5:0] ev_w     = sync2_q[5:0];

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  reg  [7:0] clkstat_q;
  reg  [7:0] err_q;
  reg  [7:0] sysctl1_q;
  reg  [7:0] serfmt_q;
  reg  [7:0] sysctl2_q;
  reg  [7:0] softmute_q;
  reg  [2:0] volcfg_q;
  reg  [5:0] ev_prev_q;
  wire [5:0] ev_rise_w = ev_w & ~ev_prev_q;
  reg  [7:0] err_set_w;
  reg  [7:0] err_d;

  always @* begin
    err_set_w = 8'h00;
    err_set_w[`AACS_ERR_MCLK]  = ev_rise_w[5]; // RULE11
    err_set_w[`AACS_ERR_PLL]   = ev_rise_w[4];
    err_set_w[`AACS_ERR_SCLK]  = ev_rise_w[3]; // RULE12
    err_set_w[`AACS_ERR_LRCLK] = ev_rise_w[2]; // RULE13
    err_set_w[`AACS_ERR_SLIP]  = ev_rise_w[1]; // RULE13
    err_set_w[`AACS_ERR_OCUR]  = ev_rise_w[0]; // RULE10
    err_d = err_q;
    if (wr_i && addr_i == `AACS_OFF_ERRFLAG)
      err_d = err_q & wdata_i; // RULE8
    err_d = (err_d | err_set_w) & `AACS_ERR_MASK; // RULE8
  end

  always @(posedge clock_i) begin
    if (srst_i) begin
      ev_prev_q  <= 6'h00;
      clkstat_q  <= 8'h00;
      err_q      <= `AACS_RST_ERRFLAG;
      sysctl1_q  <= `AACS_RST_SYSCTL1;
      serfmt_q   <= `AACS_RST_SERFMT;
      sysctl2_q  <= `AACS_RST_SYSCTL2;
      softmute_q <= `AACS_RST_SOFTMUTE;
      volcfg_q   <= `AACS_RST_VOLCFG;
    end else begin
      ev_prev_q <= ev_w;
      clkstat_q <= {fs_w, mratio_w, 2'b00}; // RULE1 RULE2
      err_q     <= err_d;
      if (wr_i) begin
        case (addr_i)
          `AACS_OFF_SYSCTL1: begin
            if (wdata_i[1:0] != `AACS_DEEMPH_RSVD) // RULE16
              sysctl1_q <= wdata_i & `AACS_SYSCTL1_MASK; // RULE14 RULE15
          end
          `AACS_OFF_SERFMT: begin
            if (wdata_i[3:0] <= `AACS_FMT_LAST) // RULE17 RULE18
              serfmt_q <= wdata_i & `AACS_SERFMT_MASK;
          end
          `AACS_OFF_SYSCTL2: sysctl2_q <= wdata_i & `AACS_SYSCTL2_MASK; // RULE19
          `AACS_OFF_SOFTMUTE: softmute_q <= wdata_i & `AACS_SOFTMUTE_MASK; // RULE20
          `AACS_OFF_VOLCFG: begin
            if (!wdata_i[2]) // RULE22
              volcfg_q <= wdata_i[2:0];
          end
          default: begin // RULE24
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port, data one cycle after the strobe
  always @(posedge clock_i) begin
    if (srst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        `AACS_OFF_CLKSTAT:  rdata_o <= clkstat_q;
        `AACS_OFF_REVID:    rdata_o <= {1'b0, REV_ID & `AACS_REVID_MASK}; // RULE7
        `AACS_OFF_ERRFLAG:  rdata_o <= err_q; // RULE9
        `AACS_OFF_SYSCTL1:  rdata_o <= sysctl1_q;
        `AACS_OFF_SERFMT:   rdata_o <= serfmt_q;
        `AACS_OFF_SYSCTL2:  rdata_o <= sysctl2_q;
        `AACS_OFF_SOFTMUTE: rdata_o <= softmute_q;
        `AACS_OFF_VOLCFG:   rdata_o <= {5'h00, volcfg_q};
        default:            rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bit-clock ratio acceptance
  reg sclk_ok_d;
  always @* begin
    case (bratio_w)
      `AACS_BR_64: sclk_ok_d = 1'b1; // RULE3
      `AACS_BR_32: sclk_ok_d = 1'b1; // RULE3
      `AACS_BR_48: sclk_ok_d = (mratio_w == `AACS_MR_192) ||
                               (mratio_w == `AACS_MR_384); // RULE3
      default:     sclk_ok_d = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Volume ramp step timer and step count
  reg [`AACS_CNT_W-1:0] step_per_w;
  reg [11:0]            steps_d;
  reg [`AACS_CNT_W-1:0] step_cnt_q;
  always @* begin
    case (fs_w)
      `AACS_FS_8, `AACS_FS_16, `AACS_FS_32:
        step_per_w = `AACS_STEP_C8; // RULE23
      `AACS_FS_11_12, `AACS_FS_22_24:
        step_per_w = `AACS_STEP_C12; // RULE23
      default:
        step_per_w = `AACS_STEP_C11; // RULE23
    endcase
    case (volcfg_q)
      `AACS_STEP_512:  steps_d = 12'h200; // RULE22
      `AACS_STEP_2048: steps_d = 12'h800; // RULE22
      `AACS_STEP_256:  steps_d = 12'h100; // RULE22
      default:         steps_d = 12'h400; // RULE22
    endcase
  end

  always @(posedge clock_i) begin
    if (srst_i) begin
      step_cnt_q     <= {`AACS_CNT_W{1'b0}};
      ramp_tick_o    <= 1'b0;
      ramp_steps_o   <= 12'h400;
      sclk_ok_o      <= 1'b0;
      dc_block_en_o  <= 1'b1;
      hard_unmute_o  <= 1'b1;
      deemph_o       <= 2'h0;
      ser_fmt_o      <= 4'h5;
      shutdown_o     <= 1'b1;
      soft_mute_o    <= 2'h0;
    end else begin
      if (step_cnt_q + 1'b1 >= step_per_w) begin
        step_cnt_q  <= {`AACS_CNT_W{1'b0}};
        ramp_tick_o <= 1'b1;
      end else begin
        step_cnt_q  <= step_cnt_q + 1'b1;
        ramp_tick_o <= 1'b0;
      end
      ramp_steps_o  <= steps_d;
      sclk_ok_o     <= sclk_ok_d;
      dc_block_en_o <= sysctl1_q[`AACS_CTL1_DCBLK]; // RULE14
      hard_unmute_o <= sysctl1_q[`AACS_CTL1_HARDUNM]; // RULE15
      deemph_o      <= sysctl1_q[1:0]; // RULE16
      ser_fmt_o     <= serfmt_q[3:0]; // RULE17
      shutdown_o    <= sysctl2_q[`AACS_CTL2_SHDN]; // RULE19
      soft_mute_o   <= softmute_q[1:0]; // RULE20
    end
  end

endmodule
`default_nettype wire

// ===== aacs_ctrl_regs_checker.sv
// Assertion checker for the amplifier control/status register bank.
// Assumes binding into aacs_ctrl_regs; sees that module's ports only.
`timescale 1ns/1ns
`default_nettype none
module aacs_ctrl_regs_checker #(
  parameter [6:0] REV_ID = 7'h2a
) (
  input wire        clock_i,
  input wire        srst_i,
  input wire [7:0]  addr_i,
  input wire [7:0]  wdata_i,
  input wire        wr_i,
  input wire        rd_i,
  input wire [7:0]  rdata_o,
  input wire [2:0]  det_fs_i,
  input wire [2:0]  det_mratio_i,
  input wire [1:0]  det_bratio_i,
  input wire        dc_block_en_o,
  input wire        hard_unmute_o,
  input wire [1:0]  deemph_o,
  input wire [3:0]  ser_fmt_o,
  input wire        shutdown_o,
  input wire [1:0]  soft_mute_o,
  input wire        sclk_ok_o,
  input wire        ramp_tick_o,
  input wire [11:0] ramp_steps_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);
  id_read_a: assert property (rd_i && addr_i == 8'h01 |=> rdata_o == {1'b0, REV_ID})
    else $error("identification read wrong");
  rdata_idle_a: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data not zero outside a read");
  clk_status_a: assert property (($stable(det_fs_i) && $stable(det_mratio_i))[*5] ##0
    (rd_i && addr_i == 8'h00) |=> rdata_o == {$past(det_fs_i), $past(det_mratio_i), 2'h0})
    else $error("clock status read wrong");
  sclk_ok_a: assert property (($stable(det_bratio_i) && $stable(det_mratio_i))[*5] |->
    sclk_ok_o == (det_bratio_i != 2'h2 || det_mratio_i == 3'h2 || det_mratio_i == 3'h4))
    else $error("bit clock acceptance wrong");
  ctl1_fields_a: assert property (wr_i && addr_i == 8'h03 && wdata_i[1:0] != 2'h1 |-> ##2
    {dc_block_en_o, hard_unmute_o, deemph_o} == {$past(wdata_i[7], 2), $past(wdata_i[5], 2),
    $past(wdata_i[1:0], 2)}) else $error("system control 1 outputs wrong");
  shutdown_a: assert property (wr_i && addr_i == 8'h05 |-> ##2 shutdown_o == $past(wdata_i[6], 2))
    else $error("shutdown output wrong");
  soft_mute_a: assert property (wr_i && addr_i == 8'h06 |-> ##2 soft_mute_o == $past(wdata_i[1:0], 2))
    else $error("soft mute output wrong");
  ser_fmt_a: assert property (wr_i && addr_i == 8'h04 && wdata_i[3:0] <= 4'h8 |-> ##2
    ser_fmt_o == $past(wdata_i[3:0], 2)) else $error("serial format output wrong");
  tick_pulse_a: assert property (ramp_tick_o |=> !ramp_tick_o)
    else $error("ramp tick longer than one cycle");
  ramp_steps_a: assert property (wr_i && addr_i == 8'h0e && wdata_i[2:0] == 3'h3 |-> ##2
    ramp_steps_o == 12'd256) else $error("ramp step count wrong");
  cover property (rd_i && addr_i == 8'h02 ##1 rdata_o != 8'h00);
  cover property (wr_i && addr_i == 8'h04 && wdata_i[3:0] > 4'h8);
  cover property (ramp_tick_o);
endmodule
bind aacs_ctrl_regs aacs_ctrl_regs_checker #(.REV_ID(REV_ID)) u_chk (.*);
`default_nettype wire

// ===== aacs_regs.vh
// Register map and constants for the amplifier control/status register bank.
// Assumes inclusion by the bank module only; definitions only.
`ifndef AACS_REGS_VH
`define AACS_REGS_VH

`define AACS_ADDR_W        8
`define AACS_DATA_W        8
`define AACS_OFF_CLKSTAT   8'h00
`define AACS_OFF_REVID     8'h01
`define AACS_OFF_ERRFLAG   8'h02
`define AACS_OFF_SYSCTL1   8'h03
`define AACS_OFF_SERFMT    8'h04
`define AACS_OFF_SYSCTL2   8'h05
`define AACS_OFF_SOFTMUTE  8'h06
`define AACS_OFF_VOLCFG    8'h0e

`define AACS_RST_SYSCTL1   8'ha0
`define AACS_RST_SERFMT    8'h05
`define AACS_RST_SYSCTL2   8'h40
`define AACS_RST_SOFTMUTE  8'h00
`define AACS_RST_ERRFLAG   8'h00
`define AACS_RST_VOLCFG    3'h1
`define AACS_ERR_MASK      8'hfa
`define AACS_SYSCTL1_MASK  8'ha3
`define AACS_SYSCTL2_MASK  8'h40
`define AACS_SOFTMUTE_MASK 8'h03
`define AACS_SERFMT_MASK   8'h0f
`define AACS_VOLCFG_MASK   8'h07
`define AACS_REVID_MASK    7'h7f

`define AACS_ERR_MCLK      7
`define AACS_ERR_PLL       6
`define AACS_ERR_SCLK      5
`define AACS_ERR_LRCLK     4
`define AACS_ERR_SLIP      3
`define AACS_ERR_OCUR      1
`define AACS_CTL1_DCBLK    7
`define AACS_CTL1_HARDUNM  5
`define AACS_CTL2_SHDN     6

`define AACS_FS_32         3'h0
`define AACS_FS_44_48      3'h3
`define AACS_FS_16         3'h4
`define AACS_FS_22_24      3'h5
`define AACS_FS_8          3'h6
`define AACS_FS_11_12      3'h7
`define AACS_MR_64         3'h0
`define AACS_MR_128        3'h1
`define AACS_MR_192        3'h2
`define AACS_MR_256        3'h3
`define AACS_MR_384        3'h4
`define AACS_MR_512        3'h5
`define AACS_BR_64         2'h0
`define AACS_BR_32         2'h1
`define AACS_BR_48         2'h2

`define AACS_FMT_LAST      4'h8
`define AACS_DEEMPH_RSVD   2'h1

`define AACS_STEP_512      3'h0
`define AACS_STEP_1024     3'h1
`define AACS_STEP_2048     3'h2
`define AACS_STEP_256      3'h3

// Ramp step period in tenths of a microsecond, and in clock cycles
`define AACS_CLK_MHZ       100
`define AACS_STEP_T8_D10   1250
`define AACS_STEP_T11_D10  907
`define AACS_STEP_T12_D10  833
`define AACS_CYC(t)        (((t) * `AACS_CLK_MHZ) / 10)
`define AACS_CNT_W         16
`define AACS_STEP_C8       16'h30d4
`define AACS_STEP_C11      16'h236e
`define AACS_STEP_C12      16'h208a

`endif

// ===== test_aacs_ctrl_regs.sv
// Self-checking bench for the amplifier control/status register bank.
// Assumes the clock source model and the bound checker.
`timescale 1ns/1ns
`default_nettype none
module test_aacs_ctrl_regs;
  localparam [6:0] REV = 7'h55; // Arbitrary value
  logic        clock_i = 1'b0;
  logic        srst_i  = 1'b1;
  logic        wr_i    = 1'b0;
  logic        rd_i    = 1'b0;
  logic        rd_seen = 1'b0;
  logic [7:0]  addr_i  = 8'h00;
  logic [7:0]  wdata_i = 8'h00;
  logic [2:0]  fs      = 3'h3;
  logic [2:0]  mr      = 3'h3;
  logic [1:0]  br      = 2'h0;
  logic [5:0]  flt     = 6'h00;
  logic [7:0]  d, exp_err = 8'h00;
  logic [7:0]  expq[$];
  int          n_fail = 0, checks_done = 0, cyc = 0, gap;
  wire  [7:0]  rdata_o;
  wire  [2:0]  det_fs, det_mr;
  wire  [1:0]  det_br, de, sm;
  wire  [5:0]  ev;
  wire  [3:0]  sf;
  wire  [11:0] steps;
  wire         dc, hu, sd, sclk_ok, tick;
  wire  [10:0] ctl = {dc, hu, de, sf, sd, sm};

  aacs_ctrl_regs #(.REV_ID(REV)) u_aacs_ctrl_regs (.clock_i(clock_i), .srst_i(srst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .det_fs_i(det_fs), .det_mratio_i(det_mr), .det_bratio_i(det_br), .ev_mclk_i(ev[5]),
    .ev_pll_i(ev[4]), .ev_sclk_i(ev[3]), .ev_lrclk_i(ev[2]), .ev_slip_i(ev[1]),
    .ev_ocur_i(ev[0]), .dc_block_en_o(dc), .hard_unmute_o(hu), .deemph_o(de),
    .ser_fmt_o(sf), .shutdown_o(sd), .soft_mute_o(sm), .sclk_ok_o(sclk_ok),
    .ramp_tick_o(tick), .ramp_steps_o(steps));
  aacs_clk_src u_aacs_clk_src (.fs_i(fs), .mr_i(mr), .br_i(br), .fault_i(flt),
    .det_fs_o(det_fs), .det_mratio_o(det_mr), .det_bratio_o(det_br), .ev_o(ev));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] v);
    @(posedge clock_i);
    {wr_i, rd_i, addr_i, wdata_i} <= {w, r, a, v};
  endtask
  task automatic wrx(input logic [7:0] a, input logic [7:0] v);
    bus(1'b1, 1'b0, a, v);
  endtask
  task automatic rdx(input logic [7:0] a, input logic [7:0] e);
    expq.push_back(e);
    bus(1'b0, 1'b1, a, 8'h00);
  endtask
  task automatic idle(input int n);
    repeat (n) bus(1'b0, 1'b0, 8'h00, 8'h00);
    #1;
  endtask
  task automatic tick_gap(output int n);
    n = 0;
    do @(negedge clock_i); while (tick !== 1'b1);
    do begin
      @(negedge clock_i);
      n++;
    end while (tick !== 1'b1);
  endtask

  initial forever #5 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    rd_seen <= rd_i;
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      n_fail++;
      stop_test;
    end
  end
  always @(negedge clock_i) if (rd_seen) chk("rdata", {4'h0, expq.pop_front()}, {4'h0, rdata_o});

  initial begin
    logic [7:0]  rst_tab [8];
    logic [2:0]  fs_tab [6];
    logic [2:0]  ebit [6];
    logic [11:0] stp_tab [5];
    rst_tab = '{8'h6c, {1'b0, REV}, 8'h00, 8'ha0, 8'h05, 8'h40, 8'h00, 8'h00};
    fs_tab = '{3'h0, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
    ebit = '{3'h7, 3'h6, 3'h5, 3'h4, 3'h3, 3'h1};
    stp_tab = '{12'd512, 12'd1024, 12'd2048, 12'd256, 12'd256};
    void'($urandom(32'h64d35c8e));
    repeat (2) @(posedge clock_i);
    srst_i <= 1'b0;
    idle(4);
    chk("controls", 12'h62c, {1'b0, ctl});
    chk("steps", 12'd1024, steps);
    foreach (rst_tab[i]) rdx(8'(i), rst_tab[i]);
    wrx(8'h00, 8'($urandom));
    wrx(8'h01, 8'($urandom));
    rdx(8'h00, 8'h6c);
    rdx(8'h01, {1'b0, REV});
    mr = 3'h5;
    foreach (fs_tab[i]) begin
      fs = fs_tab[i];
      idle(6);
      rdx(8'h00, {fs_tab[i], 3'h5, 2'h0});
    end
    br = 2'h2;
    for (int m = 0; m < 6; m++) begin
      mr = 3'(m);
      fs = (m == 2) ? 3'h0 : 3'h3;
      idle(6);
      rdx(8'h00, {fs, mr, 2'h0});
      chk("sclk_ok", {11'h0, m == 2 || m == 4}, {11'h0, sclk_ok});
    end
    foreach (ebit[i]) begin
      flt = 6'h20 >> i;
      idle(4);
      flt = 6'h00;
      idle(4);
      exp_err = exp_err | (8'h01 << ebit[i]);
      rdx(8'h02, exp_err);
    end
    wrx(8'h02, 8'hff);
    rdx(8'h02, 8'hfa);
    wrx(8'h02, 8'h0f);
    rdx(8'h02, 8'h0a);
    wrx(8'h02, 8'h00);
    rdx(8'h02, 8'h00);
    repeat (4) begin
      d = 8'($urandom) | 8'h02;
      wrx(8'h03, d);
      rdx(8'h03, d & 8'ha3);
    end
    wrx(8'h03, 8'h01);
    rdx(8'h03, d & 8'ha3);
    for (int c = 0; c < 16; c++) begin
      wrx(8'h04, 8'(c));
      if (c < 9) d = 8'(c);
      rdx(8'h04, d);
    end
    wrx(8'h05, 8'hbf);
    rdx(8'h05, 8'h00);
    for (int m = 0; m < 4; m++) begin
      wrx(8'h06, 8'(m) | 8'hfc);
      rdx(8'h06, 8'(m));
    end
    idle(2);
    chk("mute", 12'h003, {9'h0, sd, sm});
    foreach (stp_tab[i]) begin
      wrx(8'h0e, 8'(i));
      idle(2);
      chk("steps", stp_tab[i], steps);
    end
    foreach (fs_tab[i]) if (i < 2 || i == 5) begin
      fs = fs_tab[i];
      idle(8);
      tick_gap(gap);
      chk("tick_gap", (i == 0) ? 16'h30d4 : (i == 1) ? 16'h236e : 16'h208a, 16'(gap));
    end
    idle(2);
    stop_test;
  end
endmodule
`default_nettype wire
